// *** csc_charge_state_control.sv ***
// charge state machine, status pins and fault recovery of the charger
`timescale 1ns/1ns
`include "csc_cfg.svh"
// Operation
// - status pins: charging a on; complete b on; faults, sleep, absent both off.
// - blink variant: status a blinks at 0.5 Hz for over-discharge, suspend, timer faults.
// - in voltage regulation, end charge when termination current is reached.
// - timer control below threshold disables termination and timer; rising re-enables, resets.
// - timer control tied high disables only the safety timer.
// - restart on recharge drop, power-on below recharge, enable toggle, timer control event.
// - charge enable is active low; high disables charging.
// - falling edge of charge enable resets all timers and clears faults.
// - power good turns on above sleep exit, off during sleep.
// - enter sleep whenever supply is absent.
// - fault above recharge waits for drop, clears fault, starts battery detection.
// - fault below recharge enables detect current until battery rises above threshold.
// - power-on reset or enable toggle also clears a timeout fault.
// - overvoltage stops switching, status off, clears at recharge threshold.
// - host selects precharge rate with mode low, fast rate with mode high.
// - at regulation voltage go to voltage regulation regardless of mode input.
// - cell select low means 4.2 V single cell, high means 8.4 V two cells.
// - temperature suspend stops switching, holds timer count, resets nothing; the code resumes at precharge, and precharge to fast clears the timer.
// - precharge timer expiry before low voltage reached stops charge, reports fault.
module csc_charge_state_control
  import csc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire csc_sense_type sense,
  input wire csc_ttc_type timerTermCtrl,
  input wire logic chargeEnable_n,
  input wire logic hostControlled,
  input wire logic chargeRateSelect,
  input wire logic blinkVariant,
  input wire logic cellSelect,
  input wire logic [`CSC_TIMER_W-1:0] prechargeLimit,
  input wire logic [`CSC_TIMER_W-1:0] chargeLimit,
  output logic pwmEnable_q,
  output logic fastRate_q,
  output logic twoCell_q,
  output logic detectCurrentEn_q,
  output logic batteryDetectStart_q,
  output logic statusOutA_n_q,
  output logic statusOutB_n_q,
  output logic supplyGood_n_q
);
  csc_state_type state_q;
  csc_state_type state_d;
  logic ceFall;
  logic ceRise;
  logic ttcAbove;
  logic ttcRise;
  logic suspendCause;
  logic switchingState;
  logic porPending_q;
  logic restart;
  logic timerOn;
  logic termOn;
  logic timerExpired;
  logic precharging;
  logic charging;
  logic [`CSC_TIMER_W-1:0] timer_q;
  logic [`CSC_BLINK_W-1:0] blinkCnt_q;
  logic blinkPhase_q;
  logic blinkFault_q;
  logic statA;
  logic statB;

  // enable pin idles low (charging allowed); no edge is seen on the first cycle
  csc_edge_det #(
    .IDLE(1'b0)
  ) i_csc_edge_det_ce (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level(chargeEnable_n),
    .rose(ceRise),
    .fell(ceFall)
  );

  // watched as above threshold, so leaving the disabled band is a rising edge
  assign ttcAbove = ~timerTermCtrl.belowEnable;

  csc_edge_det #(
    .IDLE(1'b1)
  ) i_csc_edge_det_ttc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level(ttcAbove),
    .rose(ttcRise),
    .fell()
  );

  // pack temperature and die heat alike suspend the charge
  assign suspendCause = sense.tempOutOfRange | sense.thermalShutdown;
  assign switchingState = (state_d == CSC_PRECHG) | (state_d == CSC_FAST) |
    (state_d == CSC_VREG);
  assign timerOn = ~timerTermCtrl.belowEnable & ~timerTermCtrl.tiedHigh & ~hostControlled;
  assign termOn = ~timerTermCtrl.belowEnable & ~hostControlled;
  assign precharging = hostControlled ? ~chargeRateSelect : sense.batBelowLowv;
  assign charging = (state_q == CSC_PRECHG) | (state_q == CSC_FAST);
  assign timerExpired = timerOn &
    (timer_q >= ((state_q == CSC_PRECHG) ? prechargeLimit : chargeLimit));
  // toggle of enable, timer control rise, or power-on below recharge
  assign restart = ceFall | ceRise | ttcRise |
    (porPending_q & sense.batBelowRecharge);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      porPending_q <= 1'b1;
    end else if (sense.supplyAboveSleepExit) begin
      porPending_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      CSC_SLEEP: begin
        if (sense.supplyAboveSleepExit) begin
          state_d = sense.batBelowRecharge ? CSC_PRECHG : CSC_DONE;
        end
      end
      CSC_PRECHG, CSC_FAST: begin
        if (sense.batAtRegulation) begin
          state_d = CSC_VREG;
        end else if (timerExpired) begin
          state_d = CSC_TFAULT;
        end else if (sense.tempOutOfRange | sense.thermalShutdown) begin
          state_d = CSC_SUSPEND;
        end else begin
          state_d = precharging ? CSC_PRECHG : CSC_FAST;
        end
      end
      CSC_VREG: begin
        if (termOn & sense.termCurrentReached) begin
          state_d = CSC_DONE;
        end else if (timerExpired) begin
          state_d = CSC_TFAULT;
        end else if (sense.tempOutOfRange | sense.thermalShutdown) begin
          state_d = CSC_SUSPEND;
        end
      end
      CSC_SUSPEND: begin
        if (!suspendCause) begin
          state_d = CSC_PRECHG;
        end
      end
      CSC_DONE: begin
        if (sense.batBelowRecharge) begin
          state_d = CSC_DETECT;
        end
      end
      CSC_TFAULT: begin
        // this branch clears it only once the battery has been seen above recharge; a restart also clears it
        if (!detectCurrentEn_q & sense.batBelowRecharge) begin
          state_d = CSC_DETECT;
        end
      end
      CSC_OVP: begin
        if (sense.batBelowRecharge) begin
          state_d = CSC_DETECT;
        end
      end
      CSC_DETECT: begin
        state_d = CSC_PRECHG;
      end
      default: begin
        state_d = CSC_SLEEP;
      end
    endcase
    if (sense.batOvervoltage & (state_q != CSC_SLEEP)) begin
      state_d = CSC_OVP;
    end else if (restart & (state_q != CSC_SLEEP)) begin
      state_d = CSC_PRECHG;
    end
    if (!sense.supplyAboveSleepExit) begin
      state_d = CSC_SLEEP;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CSC_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  // timer holds in suspend, clears on restart or when the timer is re-enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= '0;
    end else if (restart | !timerOn) begin
      timer_q <= '0;
    end else if ((state_q == CSC_PRECHG) & (state_d == CSC_FAST)) begin
      timer_q <= '0;
    end else if (charging | (state_q == CSC_VREG)) begin
      timer_q <= timer_q + 1'b1;
    end
  end

  // detect current on while a timed-out battery stays below recharge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      detectCurrentEn_q <= 1'b0;
    end else if (state_d != CSC_TFAULT) begin
      detectCurrentEn_q <= 1'b0;
    end else if (state_q != CSC_TFAULT) begin
      detectCurrentEn_q <= sense.batBelowRecharge;
    end else if (!sense.batBelowRecharge) begin
      detectCurrentEn_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      batteryDetectStart_q <= 1'b0;
    end else begin
      batteryDetectStart_q <= (state_d == CSC_DETECT) & (state_q != CSC_DETECT);
    end
  end

  // enable high blocks switching; its rising edge restarts the charge at precharge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwmEnable_q <= 1'b0;
    end else begin
      pwmEnable_q <= switchingState & ~chargeEnable_n;
    end
  end

  // regulation keeps the fast-rate loop selected
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fastRate_q <= 1'b0;
    end else begin
      fastRate_q <= (state_d == CSC_FAST) | (state_d == CSC_VREG);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      twoCell_q <= 1'b0;
    end else begin
      twoCell_q <= cellSelect;
    end
  end

  // 0.5 Hz blink, one second per phase
  // free running, so a new fault may show a shortened first phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_q <= '0;
    end else if (blinkCnt_q == `CSC_BLINK_W'(`CSC_BLINK_CYCLES - 1)) begin
      blinkCnt_q <= '0;
    end else begin
      blinkCnt_q <= blinkCnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blinkPhase_q <= 1'b0;
    end else if (blinkCnt_q == `CSC_BLINK_W'(`CSC_BLINK_CYCLES - 1)) begin
      blinkPhase_q <= ~blinkPhase_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blinkFault_q <= 1'b0;
    end else begin
      blinkFault_q <= (state_d == CSC_SUSPEND) | (state_d == CSC_TFAULT) |
        (sense.batShort & (state_d != CSC_SLEEP));
    end
  end

  always_comb begin
    statA = charging | (state_q == CSC_VREG);
    statB = (state_q == CSC_DONE);
    if (blinkVariant & blinkFault_q) begin
      statA = blinkPhase_q;
      statB = 1'b0;
    end
  end

  csc_od_reg i_csc_od_reg_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lampOn(statA),
    .pin_n_q(statusOutA_n_q)
  );

  csc_od_reg i_csc_od_reg_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lampOn(statB),
    .pin_n_q(statusOutB_n_q)
  );

  csc_od_reg i_csc_od_reg_pg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lampOn(sense.supplyAboveSleepExit),
    .pin_n_q(supplyGood_n_q)
  );
endmodule

// one open-drain indicator, transistor released unless the lamp is asked for
module csc_od_reg (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic lampOn,
  output logic pin_n_q
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_n_q <= `CSC_OD_OFF;
    end else begin
      pin_n_q <= lampOn ? `CSC_OD_ON : `CSC_OD_OFF;
    end
  end
endmodule

// edge detector of a pin level, quiet on the first cycle after reset
module csc_edge_det #(
  parameter logic IDLE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic level,
  output logic rose,
  output logic fell
);
  logic last_q;
  logic seen_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= IDLE;
    end else begin
      last_q <= level;
    end
  end

  // without this a pin held away from idle through reset would fake an edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  assign rose = seen_q & ~last_q & level;
  assign fell = seen_q & last_q & ~level;
endmodule

// *** csc_cfg.svh ***
// timing and encoding constants for the charge state controller
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_CLK_HZ 100000000
`define CSC_BLINK_HALF_S 1
`define CSC_BLINK_CYCLES (`CSC_CLK_HZ * `CSC_BLINK_HALF_S)
`define CSC_BLINK_W 27
`define CSC_TIMER_W 40
`define CSC_OD_ON 1'b0
`define CSC_OD_OFF 1'b1
`endif

// *** csc_pkg.sv ***
// types shared by the charge state controller
package csc_pkg;
  typedef enum logic [8:0] {
    CSC_SLEEP = 9'h001,
    CSC_PRECHG = 9'h002,
    CSC_FAST = 9'h004,
    CSC_VREG = 9'h008,
    CSC_DONE = 9'h010,
    CSC_SUSPEND = 9'h020,
    CSC_TFAULT = 9'h040,
    CSC_OVP = 9'h080,
    CSC_DETECT = 9'h100
  } csc_state_type;

  typedef struct packed {
    logic batBelowLowv;
    logic batBelowRecharge;
    logic batAtRegulation;
    logic batShort;
    logic batOvervoltage;
    logic termCurrentReached;
    logic tempOutOfRange;
    logic thermalShutdown;
    logic supplyAboveSleepExit;
  } csc_sense_type;

  typedef struct packed {
    logic belowEnable;
    logic tiedHigh;
  } csc_ttc_type;
endpackage

// *** csc_chk_asserts.sv ***
// port assertions of the charge state controller
`timescale 1ns/1ns
module csc_chk
  import csc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire csc_sense_type sense,
  input wire logic chargeEnable_n,
  input wire logic pwmEnable_q,
  input wire logic detectCurrentEn_q,
  input wire logic batteryDetectStart_q,
  input wire logic statusOutA_n_q,
  input wire logic statusOutB_n_q,
  input wire logic supplyGood_n_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sleep_pg_a: assert property (!sense.supplyAboveSleepExit |=> supplyGood_n_q)
    else $error("power good on without supply");
  sleep_pwm_a: assert property (!sense.supplyAboveSleepExit |=> !pwmEnable_q)
    else $error("switching without supply");
  sleep_stat_a: assert property (!sense.supplyAboveSleepExit |-> ##2 statusOutA_n_q && statusOutB_n_q)
    else $error("status lit in sleep");
  enable_gate_a: assert property (chargeEnable_n |=> !pwmEnable_q)
    else $error("switching while disabled");
  ovp_stop_a: assert property (sense.batOvervoltage |=> !pwmEnable_q)
    else $error("switching in overvoltage");
  status_excl_a: assert property (!statusOutA_n_q |-> statusOutB_n_q)
    else $error("both status lines on");
  detect_pwm_a: assert property (detectCurrentEn_q |-> !pwmEnable_q)
    else $error("detect current while switching");
  detect_pulse_a: assert property (batteryDetectStart_q |=> !batteryDetectStart_q)
    else $error("detect start longer than a cycle");
endmodule
bind csc_charge_state_control csc_chk i_csc_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .sense(sense), .chargeEnable_n(chargeEnable_n), .pwmEnable_q(pwmEnable_q),
  .detectCurrentEn_q(detectCurrentEn_q), .batteryDetectStart_q(batteryDetectStart_q),
  .statusOutA_n_q(statusOutA_n_q), .statusOutB_n_q(statusOutB_n_q),
  .supplyGood_n_q(supplyGood_n_q));

// *** csc_led_model.sv ***
// leds on the pulled-up open-drain status and power good lines
`timescale 1ns/1ns
module csc_led_model (
  input wire logic statusA_n,
  input wire logic statusB_n,
  input wire logic supplyGood_n,
  output logic ledA,
  output logic ledB,
  output logic ledPg
);
  // a released line reads the pull-up, so only a low pin lights
  assign ledA = !statusA_n;
  assign ledB = !statusB_n;
  assign ledPg = !supplyGood_n;
endmodule

// *** test_charge_state_control.sv ***
// scenario bench of the charge state controller
`timescale 1ns/1ns
module test_charge_state_control
  import csc_pkg::*;
;
  logic clk_sys, rst_n, chargeEn_n, host, rate, blink, cells;
  logic pwm, fast, two, det, detStart, stA_n, stB_n, pg_n, ledA, ledB, ledPg;
  csc_sense_type s;
  csc_ttc_type timer_term_ctrl;
  int failures, comparisons;
  csc_charge_state_control i_csc_charge_state_control (.clk_sys(clk_sys), .rst_n(rst_n),
    .sense(s), .timerTermCtrl(timer_term_ctrl), .chargeEnable_n(chargeEn_n), .hostControlled(host),
    .chargeRateSelect(rate), .blinkVariant(blink), .cellSelect(cells),
    .prechargeLimit(40'h0000000014), .chargeLimit(40'h0000000064), .pwmEnable_q(pwm),
    .fastRate_q(fast), .twoCell_q(two), .detectCurrentEn_q(det),
    .batteryDetectStart_q(detStart), .statusOutA_n_q(stA_n), .statusOutB_n_q(stB_n),
    .supplyGood_n_q(pg_n));
  csc_led_model i_csc_led_model (.statusA_n(stA_n), .statusB_n(stB_n),
    .supplyGood_n(pg_n), .ledA(ledA), .ledB(ledB), .ledPg(ledPg));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(logic got, logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return pwm;
      1: return stB_n;
      2: return det;
      default: return detStart;
    endcase
  endfunction
  // bounded so a stuck state ends the run instead of hanging it
  task automatic waitOn(int k, logic v);
    int n;
    n = 0;
    while (pick(k) !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > 300) begin
        failures++;
        $display("MISMATCH %0t wait ran out", $time);
        tally_and_finish();
      end
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic tStart();
    s.supplyAboveSleepExit = 1'b1;
    cyc(3);
    chk(pwm, 1'b1);
    chk(ledA, 1'b1);
    chk(ledB, 1'b0);
    chk(ledPg, 1'b1);
    chk(two, 1'b1);
  endtask
  task automatic tSuspend();
    blink = 1'b1;
    s.tempOutOfRange = 1'b1;
    cyc(3);
    chk(pwm, 1'b0);
    chk(ledA, 1'b0);
    chk(ledB, 1'b0);
    s.tempOutOfRange = 1'b0;
    blink = 1'b0;
    cyc(3);
    chk(pwm, 1'b1);
    chk(ledA, 1'b1);
  endtask
  task automatic tRate();
    host = 1'b1;
    rate = 1'b1;
    cyc(2);
    chk(fast, 1'b1);
    rate = 1'b0;
    cyc(2);
    chk(fast, 1'b0);
    s.batBelowLowv = 1'b0;
    s.batBelowRecharge = 1'b0;
    s.batAtRegulation = 1'b1;
    cyc(2);
    chk(fast, 1'b1);
    host = 1'b0;
  endtask
  task automatic tTerm();
    timer_term_ctrl.belowEnable = 1'b1;
    s.termCurrentReached = 1'b1;
    cyc(4);
    chk(ledB, 1'b0);
    timer_term_ctrl.belowEnable = 1'b0;
    waitOn(1, 1'b0);
    chk(ledA, 1'b0);
  endtask
  task automatic tFault();
    s.batAtRegulation = 1'b0;
    s.termCurrentReached = 1'b0;
    s.batBelowLowv = 1'b1;
    s.batBelowRecharge = 1'b1;
    waitOn(0, 1'b1);
    waitOn(2, 1'b1);
    cyc(2);
    chk(pwm, 1'b0);
    chk(ledA, 1'b0);
    s.batBelowRecharge = 1'b0;
    waitOn(2, 1'b0);
    s.batBelowRecharge = 1'b1;
    waitOn(3, 1'b1);
    waitOn(2, 1'b1);
    chargeEn_n = 1'b1;
    cyc(2);
    chk(pwm, 1'b0);
    chargeEn_n = 1'b0;
    waitOn(0, 1'b1);
  endtask
  task automatic tOvp();
    s.batOvervoltage = 1'b1;
    cyc(3);
    chk(pwm, 1'b0);
    chk(ledA, 1'b0);
    chk(ledB, 1'b0);
    s.batOvervoltage = 1'b0;
    waitOn(0, 1'b1);
  endtask
  task automatic tSleep();
    s.supplyAboveSleepExit = 1'b0;
    cyc(3);
    chk(pwm, 1'b0);
    chk(ledPg, 1'b0);
    chk(ledA, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    s = '0;
    timer_term_ctrl = '0;
    s.batBelowLowv = 1'b1;
    s.batBelowRecharge = 1'b1;
    {chargeEn_n, host, rate, blink, cells} = 5'h01;
    cyc(3);
    rst_n = 1'b1;
    tStart();
    tSuspend();
    tRate();
    tTerm();
    tFault();
    tOvp();
    tSleep();
    tally_and_finish();
  end
endmodule
